// ==== design/sysmgr_pkg.sv ====
package sysmgr_pkg;
    localparam logic [31:0] ADDR_BUS_PRIORITY_CONTROL   = 32'hfff0_0004;
    localparam logic [31:0] ADDR_MAIN_PLL_CONTROL       = 32'hfff0_0008;
    localparam logic [31:0] ADDR_CLOCK_GATE_AND_SOURCE  = 32'hfff0_000c;
    localparam logic [31:0] ADDR_SECONDARY_PLL_CONTROL  = 32'hfff0_0010;
    localparam logic [7:0]  ADDR_LOW_MASK               = 8'hff;

    localparam int BIT_PRIORITY_SCHEME = 0;
    localparam int BIT_BOOST_ENABLE    = 1;
    localparam int BIT_BOOST_ACTIVE    = 2;
    localparam logic [31:0] ARB_RW_MASK = 32'h0000_0007;
    localparam logic [31:0] ARB_RESET   = 32'h0000_0000;

    localparam int BIT_PLL_SLEEP   = 16;
    localparam int FB_DIV_MSB      = 15;
    localparam int FB_DIV_LSB      = 7;
    localparam int OUT_DIV_MSB     = 6;
    localparam int OUT_DIV_LSB     = 5;
    localparam int IN_DIV_MSB      = 4;
    localparam int IN_DIV_LSB      = 0;
    localparam logic [31:0] PLL_RW_MASK      = 32'h0001_ffff;
    localparam logic [31:0] MAIN_PLL_RESET   = 32'h0000_2f01;
    localparam logic [31:0] SEC_PLL_RESET    = 32'h0001_0000;
    localparam logic [9:0]  DIV_OFFSET       = 10'h002;

    localparam int BIT_USB_SOURCE  = 15;
    localparam int BIT_XTAL_OR_PLL = 4;
    localparam int RATE_MSB        = 3;
    localparam int RATE_LSB        = 1;
    localparam int BIT_SOFT_RESET  = 0;
    localparam logic [31:0] CLOCK_GATE_AND_SOURCE_RW_MASK = 32'h1fff_fdfe;
    localparam logic [31:0] CLOCK_GATE_AND_SOURCE_GATES   = 32'h1fff_7de0;
    localparam logic [31:0] CLOCK_GATE_AND_SOURCE_RESET   = 32'h1fff_7de8;

    localparam logic [2:0] RATE_SLOW = 3'h0;
    localparam logic [2:0] RATE_24M  = 3'h1;
    localparam logic [2:0] RATE_48M  = 3'h2;
    localparam logic [2:0] RATE_60M  = 3'h3;
    localparam logic [2:0] RATE_80M  = 3'h4;

    localparam int NUM_MASTERS = 9;
    localparam int CORE_INDEX  = 8;
    localparam logic [3:0] SOFT_RESET_CYCLES = 4'h4;

    typedef enum logic [2:0] {
        ARB_IDLE  = 3'b001,
        ARB_GRANT = 3'b010,
        ARB_HOLD  = 3'b100
    } arb_state_t;
endpackage

// ==== design/bus_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter
    import sysmgr_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic [NUM_MASTERS-1:0] req,
    input  wire logic                   rotate_mode,
    input  wire logic                   core_top,
    output logic      [NUM_MASTERS-1:0] grant
);
    ////////////////////////////////////////////////////////////////
    arb_state_t             state_q;
    arb_state_t             state_d;
    logic [NUM_MASTERS-1:0] grant_q;
    logic [NUM_MASTERS-1:0] pick_fixed;
    logic [NUM_MASTERS-1:0] pick_rr;
    logic [NUM_MASTERS-1:0] pick;
    logic [NUM_MASTERS-1:0] last_q;
    logic [NUM_MASTERS-1:0] rot_req;
    logic [NUM_MASTERS-1:0] rot_pick;
    logic [3:0]             last_idx;

    assign grant = grant_q;

    // Index 0 is the top of the fixed order, the core sits last unless core_top lifts it to the top.
    always_comb begin
        pick_fixed = '0;
        if (core_top && req[CORE_INDEX]) begin
            pick_fixed[CORE_INDEX] = 1'b1;
        end else begin
            for (int i = NUM_MASTERS - 1; i >= 0; i--) begin
                if (req[i]) begin
                    pick_fixed = '0;
                    pick_fixed[i] = 1'b1;
                end
            end
        end
    end

    // Rotate the request vector so the master after the last owner comes first.
    always_comb begin
        last_idx = 4'h0;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            if (last_q[i]) begin
                last_idx = 4'(i);
            end
        end
        for (int i = 0; i < NUM_MASTERS; i++) begin
            rot_req[i] = req[(i + int'(last_idx) + 1) % NUM_MASTERS];
        end
        rot_pick = '0;
        for (int i = NUM_MASTERS - 1; i >= 0; i--) begin
            if (rot_req[i]) begin
                rot_pick = '0;
                rot_pick[i] = 1'b1;
            end
        end
        pick_rr = '0;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            if (rot_pick[i]) begin
                pick_rr[(i + int'(last_idx) + 1) % NUM_MASTERS] = 1'b1;
            end
        end
        pick = rotate_mode ? pick_rr : pick_fixed;
    end

    always_comb begin
        case (state_q)
            ARB_IDLE:  state_d = (|req) ? ARB_GRANT : ARB_IDLE;
            ARB_GRANT: state_d = (|(req & grant_q)) ? ARB_HOLD : ARB_IDLE;
            ARB_HOLD:  state_d = (|(req & grant_q)) ? ARB_HOLD : ARB_IDLE;
            default:   state_d = ARB_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= ARB_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // The owner keeps the grant until it drops its request.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            grant_q <= '0;
            last_q  <= '0;
        end else if (state_q == ARB_IDLE) begin
            grant_q <= pick;
            if (|pick) begin
                last_q <= pick;
            end
        end else if (state_d == ARB_IDLE) begin
            grant_q <= '0;
        end
    end
endmodule
`default_nettype wire

// ==== design/sys_clock_and_arb_control.sv ====
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sys_clock_and_arb_control
    import sysmgr_pkg::*;
(
    input  wire logic                               clk_sys,
    input  wire logic                               resetn,
    input  wire logic [31:0]                        s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    input  wire logic [31:0]                        s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [31:0]                             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    input  wire logic                               boot_clock_strap,
    input  wire logic                               core_irq_pending,
    input  wire logic [sysmgr_pkg::NUM_MASTERS-1:0] bus_request,
    output logic      [sysmgr_pkg::NUM_MASTERS-1:0] bus_grant,
    output logic [28:0]                             peripheral_clock_run,
    output logic                                    usb_48m_source,
    output logic                                    crystal_or_pll_select,
    output logic [2:0]                              pll_rate_select,
    output logic                                    soft_reset_pulse,
    output logic                                    pll_sleep,
    output logic [9:0]                              feedback_factor,
    output logic [5:0]                              input_factor,
    output logic [2:0]                              output_factor,
    output logic                                    secondary_pll_sleep
);
    ////////////////////////////////////////////////////////////////
    logic [31:0] arb_q;
    logic [31:0] main_pll_q;
    logic [31:0] clock_gate_and_source_q;
    logic [31:0] sec_pll_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;
    logic        wr_fire;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] wr_mask;
    logic        wr_hit;
    logic        strap_s1_q;
    logic        strap_s2_q;
    logic        strap_s3_q;
    logic [2:0]  strap_fill_q;
    logic        strap_done_q;
    logic [3:0]  srst_cnt_q;
    logic        core_top;
    logic        rd_hit;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////
    // Write channel: address and data are caught independently, then one response.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_fire = (aw_held_q || (s_axi_awvalid && s_axi_awready))
                  && (w_held_q || (s_axi_wvalid && s_axi_wready));

    always_comb begin
        wr_mask = '0;
        for (int b = 0; b < 4; b++) begin
            wr_mask[b*8 +: 8] = {8{w_held_q ? wstrb_q[b] : s_axi_wstrb[b]}};
        end
    end

    assign wr_hit = (wr_addr[31:2] == ADDR_BUS_PRIORITY_CONTROL[31:2])
                 || (wr_addr[31:2] == ADDR_MAIN_PLL_CONTROL[31:2])
                 || (wr_addr[31:2] == ADDR_CLOCK_GATE_AND_SOURCE[31:2])
                 || (wr_addr[31:2] == ADDR_SECONDARY_PLL_CONTROL[31:2]);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Arbitration control register.
    assign core_top = !arb_q[BIT_PRIORITY_SCHEME] && arb_q[BIT_BOOST_ENABLE] && arb_q[BIT_BOOST_ACTIVE];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            arb_q <= ARB_RESET;
        end else begin
            if (wr_fire && wr_addr[31:2] == ADDR_BUS_PRIORITY_CONTROL[31:2]) begin
                arb_q[BIT_PRIORITY_SCHEME] <= wr_mask[BIT_PRIORITY_SCHEME]
                    ? wr_data[BIT_PRIORITY_SCHEME] : arb_q[BIT_PRIORITY_SCHEME];
                arb_q[BIT_BOOST_ENABLE] <= wr_mask[BIT_BOOST_ENABLE]
                    ? wr_data[BIT_BOOST_ENABLE] : arb_q[BIT_BOOST_ENABLE];
                if (wr_mask[BIT_BOOST_ACTIVE] && !wr_data[BIT_BOOST_ACTIVE]) begin
                    arb_q[BIT_BOOST_ACTIVE] <= 1'b0;
                end
            end
            // A pending interrupt wins over a clear in the same cycle.
            if (arb_q[BIT_BOOST_ENABLE] && !arb_q[BIT_PRIORITY_SCHEME] && core_irq_pending) begin
                arb_q[BIT_BOOST_ACTIVE] <= 1'b1;
            end
        end
    end

    bus_arbiter u_arbiter (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .req         (bus_request),
        .rotate_mode (arb_q[BIT_PRIORITY_SCHEME]),
        .core_top    (core_top),
        .grant       (bus_grant)
    );

    ////////////////////////////////////////////////////////////////
    // PLL control registers.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            main_pll_q <= MAIN_PLL_RESET;
            sec_pll_q  <= SEC_PLL_RESET;
        end else if (wr_fire) begin
            if (wr_addr[31:2] == ADDR_MAIN_PLL_CONTROL[31:2]) begin
                main_pll_q <= (main_pll_q & ~(wr_mask & PLL_RW_MASK))
                            | (wr_data & wr_mask & PLL_RW_MASK);
            end
            if (wr_addr[31:2] == ADDR_SECONDARY_PLL_CONTROL[31:2]) begin
                sec_pll_q <= (sec_pll_q & ~(wr_mask & PLL_RW_MASK))
                           | (wr_data & wr_mask & PLL_RW_MASK);
            end
        end
    end

    // Fout = Fin * feedback_factor / input_factor / output_factor.
    assign pll_sleep           = main_pll_q[BIT_PLL_SLEEP];
    assign feedback_factor     = {1'b0, main_pll_q[FB_DIV_MSB:FB_DIV_LSB]} + DIV_OFFSET;
    assign input_factor        = 6'({1'b0, main_pll_q[IN_DIV_MSB:IN_DIV_LSB]} + DIV_OFFSET[5:0]);
    assign secondary_pll_sleep = sec_pll_q[BIT_PLL_SLEEP];

    always_comb begin
        case (main_pll_q[OUT_DIV_MSB:OUT_DIV_LSB])
            2'h0:    output_factor = 3'h1;
            2'h3:    output_factor = 3'h4;
            default: output_factor = 3'h2;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Strap passes three flops; latched once the last two agree after release.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            strap_s1_q   <= 1'b0;
            strap_s2_q   <= 1'b0;
            strap_s3_q   <= 1'b0;
            strap_fill_q <= 3'h0;
        end else begin
            strap_s1_q   <= boot_clock_strap;
            strap_s2_q   <= strap_s1_q;
            strap_s3_q   <= strap_s2_q;
            strap_fill_q <= {strap_fill_q[1:0], 1'b1};
        end
    end

    // Clock-select register; software reset pulse counts down after a one is written.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clock_gate_and_source_q     <= CLOCK_GATE_AND_SOURCE_RESET;
            strap_done_q <= 1'b0;
            srst_cnt_q   <= '0;
        end else begin
            // The reset zeros in the flops agree at once, so wait until the pin has reached the last one.
            if (!strap_done_q && strap_fill_q[2] && strap_s2_q == strap_s3_q) begin
                strap_done_q              <= 1'b1;
                clock_gate_and_source_q[BIT_XTAL_OR_PLL] <= strap_s3_q;
            end
            if (wr_fire && wr_addr[31:2] == ADDR_CLOCK_GATE_AND_SOURCE[31:2]) begin
                clock_gate_and_source_q <= (clock_gate_and_source_q & ~(wr_mask & CLOCK_GATE_AND_SOURCE_RW_MASK))
                          | (wr_data & wr_mask & CLOCK_GATE_AND_SOURCE_RW_MASK);
                if (wr_mask[BIT_SOFT_RESET] && wr_data[BIT_SOFT_RESET]) begin
                    srst_cnt_q <= SOFT_RESET_CYCLES;
                end else if (srst_cnt_q != 4'h0) begin
                    srst_cnt_q <= srst_cnt_q - 4'h1;
                end
            end else if (srst_cnt_q != 4'h0) begin
                srst_cnt_q <= srst_cnt_q - 4'h1;
            end
        end
    end

    // Software is expected to leave the PLL source before dropping to the slow rate.
    assign peripheral_clock_run  = clock_gate_and_source_q[28:0] & CLOCK_GATE_AND_SOURCE_GATES[28:0];
    assign usb_48m_source        = clock_gate_and_source_q[BIT_USB_SOURCE];
    assign crystal_or_pll_select = clock_gate_and_source_q[BIT_XTAL_OR_PLL];
    assign pll_rate_select       = clock_gate_and_source_q[RATE_MSB:RATE_LSB];
    assign soft_reset_pulse      = (srst_cnt_q != 4'h0);

    ////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data.
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = '0;
        case (s_axi_araddr[31:2])
            ADDR_BUS_PRIORITY_CONTROL[31:2]:  rd_word = arb_q & ARB_RW_MASK;
            ADDR_MAIN_PLL_CONTROL[31:2]:      rd_word = main_pll_q;
            ADDR_CLOCK_GATE_AND_SOURCE[31:2]: rd_word = clock_gate_and_source_q & CLOCK_GATE_AND_SOURCE_RW_MASK;
            ADDR_SECONDARY_PLL_CONTROL[31:2]: rd_word = sec_pll_q;
            default:                          rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== sim/sys_clock_and_arb_control_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module sys_clock_and_arb_control_checker (
    input wire logic                               clk_sys,
    input wire logic                               resetn,
    input wire logic                               s_axi_rvalid,
    input wire logic [31:0]                        s_axi_rdata,
    input wire logic [1:0]                         s_axi_rresp,
    input wire logic [sysmgr_pkg::NUM_MASTERS-1:0] bus_request,
    input wire logic [sysmgr_pkg::NUM_MASTERS-1:0] bus_grant,
    input wire logic                               soft_reset_pulse,
    input wire logic [2:0]                         output_factor,
    input wire logic [28:0]                        peripheral_clock_run
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // The pulse must be long enough for slow consumers, but never stick.
    sequence pulse_run;
        soft_reset_pulse [*4] ##1 !soft_reset_pulse;
    endsequence

    grant_one_hot_a: assert property ($onehot0(bus_grant))
        else $error("more than one bus grant");
    grant_hold_a: assert property ((bus_grant & bus_request) != 0 |=> $stable(bus_grant))
        else $error("grant moved while owner still requests");
    grant_drop_a: assert property (bus_grant != 0 && (bus_grant & bus_request) == 0 |=> bus_grant == 0)
        else $error("grant kept after release");
    grant_serve_a: assert property (bus_grant == 0 && bus_request != 0 |-> ##[1:2] bus_grant != 0)
        else $error("pending request never granted");
    reset_pulse_a: assert property ($rose(soft_reset_pulse) |-> pulse_run)
        else $error("soft reset pulse has wrong length");
    out_div_a: assert property (output_factor == 3'h1 || output_factor == 3'h2 || output_factor == 3'h4)
        else $error("illegal output divide factor");
    gate_rsvd_a: assert property (peripheral_clock_run[9] == 1'h0 && peripheral_clock_run[4:0] == 5'h00)
        else $error("reserved gate bit driven");
    read_rsvd_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:29] == 3'h0)
        else $error("reserved read bits not zero");
endmodule
////////////////////////////////////////////////////////////
bind sys_clock_and_arb_control sys_clock_and_arb_control_checker u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .bus_request(bus_request),
    .bus_grant(bus_grant), .soft_reset_pulse(soft_reset_pulse), .output_factor(output_factor),
    .peripheral_clock_run(peripheral_clock_run)
);
`default_nettype wire

// ==== sim/sys_clock_and_arb_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sys_clock_and_arb_control_tb
    import sysmgr_pkg::*;
;
    localparam logic [31:0] ARB = ADDR_BUS_PRIORITY_CONTROL;
    localparam logic [31:0] PLL = ADDR_MAIN_PLL_CONTROL;
    localparam logic [31:0] CKS = ADDR_CLOCK_GATE_AND_SOURCE;
    localparam logic [31:0] PL2 = ADDR_SECONDARY_PLL_CONTROL;
    logic        clk_sys = 1'b0, resetn = 1'b0, irq = 1'b0, strap = 1'b1;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [8:0]  req = 9'h000, g;
    logic [1:0]  rs;
    wire logic   awready, wready, bvalid, arready, rvalid, usb, xtal, pulse, sleep, sleep2;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [8:0]  grant;
    wire logic [28:0] run;
    wire logic [2:0]  rate, ofac;
    wire logic [9:0]  ffac;
    wire logic [5:0]  ifac;
    int miscompares = 0, n_tests = 0, cycles = 0, pulses = 0;

    sys_clock_and_arb_control u_sys_clock_and_arb_control (
        .clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .boot_clock_strap(strap),
        .core_irq_pending(irq), .bus_request(req), .bus_grant(grant), .peripheral_clock_run(run),
        .usb_48m_source(usb), .crystal_or_pll_select(xtal), .pll_rate_select(rate),
        .soft_reset_pulse(pulse), .pll_sleep(sleep), .feedback_factor(ffac), .input_factor(ifac),
        .output_factor(ofac), .secondary_pll_sleep(sleep2)
    );

    always #2 clk_sys = ~clk_sys;
    // Counted on the falling edge so the count never races the pulse's own update.
    always @(negedge clk_sys) begin
        if (pulse === 1'b1) pulses++;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Readiness is looked at on the falling edge; the transfer happens at the next rising edge.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, ra, rw;
        @(posedge clk_sys);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        while (!(ta && tw)) begin
            @(negedge clk_sys);
            ra = awvalid && awready;
            rw = wvalid && wready;
            @(posedge clk_sys);
            if (ra) begin awvalid <= 1'b0; ta = 1'b1; end
            if (rw) begin wvalid <= 1'b0; tw = 1'b1; end
        end
        do @(negedge clk_sys); while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge clk_sys);
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [31:0] a);
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(negedge clk_sys); while (arready !== 1'b1);
        @(posedge clk_sys);
        arvalid <= 1'b0;
        do @(negedge clk_sys); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        @(posedge clk_sys);
        rready <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        rdr(a);
        check(rd, e);
        check(32'(rs), 32'h0000_0000);
    endtask

    task automatic gw();
        do @(negedge clk_sys); while (grant === 9'h000);
        g = grant;
    endtask

    task automatic set_req(input logic [8:0] r);
        @(posedge clk_sys);
        req <= r;
        if (r == 9'h000) do @(negedge clk_sys); while (grant !== 9'h000);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(ARB, 32'h0000_0000);
        chk(PLL, 32'h0000_2f01);
        chk(CKS, 32'h1fff_7df8);
        chk(PL2, 32'h0001_0000);
        check(32'(run), 32'h1fff_7de0);
        check(32'({ffac, ifac, ofac, xtal, sleep}), 32'({10'h060, 6'h03, 3'h1, 1'h1, 1'h0}));
        $display("reset values done");
    endtask

    task automatic t_bus();
        wr(32'hfff0_0014, 32'h0000_0001);
        check(32'(rs), 32'h0000_0002);
        rdr(32'hfff0_0000);
        check(32'(rs), 32'h0000_0002);
        wr(ARB, 32'hffff_ffff);
        chk(ARB, 32'h0000_0003);
        $display("bus access done");
    endtask

    task automatic t_boost();
        wr(ARB, 32'h0000_0002);
        @(posedge clk_sys);
        irq <= 1'b1;
        chk(ARB, 32'h0000_0006);
        @(posedge clk_sys);
        irq <= 1'b0;
        set_req(9'h101);
        gw();
        check(32'(g), 32'h0000_0100);
        set_req(9'h000);
        chk(ARB, 32'h0000_0006);
        wr(ARB, 32'h0000_0004);
        chk(ARB, 32'h0000_0004);
        set_req(9'h101);
        gw();
        check(32'(g), 32'h0000_0001);
        set_req(9'h000);
        wr(ARB, 32'h0000_0003);
        @(posedge clk_sys);
        irq <= 1'b1;
        chk(ARB, 32'h0000_0003);
        @(posedge clk_sys);
        irq <= 1'b0;
        $display("core boost done");
    endtask

    task automatic t_fixed();
        wr(ARB, 32'h0000_0000);
        set_req(9'h1ff);
        for (int i = 0; i < 9; i++) begin
            gw();
            check(32'(g), 32'h0000_0001 << i);
            repeat (2) @(negedge clk_sys);
            check(32'(grant), 32'(g));
            set_req(req & ~g);
            do @(negedge clk_sys); while (grant !== 9'h000);
        end
        $display("fixed order done");
    endtask

    task automatic t_rot();
        logic [8:0] p;
        wr(ARB, 32'h0000_0001);
        set_req(9'h1ff);
        gw();
        for (int i = 0; i < 10; i++) begin
            p = g;
            set_req(9'h1ff & ~p);
            do @(negedge clk_sys); while (grant !== 9'h000);
            gw();
            check(32'(g), 32'({p[7:0], p[8]}));
        end
        set_req(9'h000);
        $display("rotate order done");
    endtask

    task automatic t_pll();
        logic [2:0] no [4] = '{3'h1, 3'h2, 3'h2, 3'h4};
        for (int c = 0; c < 4; c++) begin
            wr(PLL, 32'(c) << 5);
            check(32'({ofac, ffac, ifac}), 32'({no[c], 10'h002, 6'h02}));
        end
        wr(PLL, 32'hffff_ffff);
        chk(PLL, 32'h0001_ffff);
        check(32'({sleep, ffac, ifac}), 32'({1'h1, 10'h201, 6'h21}));
        wr(PL2, 32'h0000_0000);
        chk(PL2, 32'h0000_0000);
        check(32'(sleep2), 32'h0000_0000);
        $display("pll control done");
    endtask

    task automatic t_clk();
        wr(CKS, 32'h1fff_7de8);
        wr(CKS, 32'h0000_0000);
        chk(CKS, 32'h0000_0000);
        check(32'({run, usb, xtal, rate}), 32'h0000_0000);
        for (int c = 0; c < 5; c++) begin
            wr(CKS, 32'h0000_0010 | (32'(c) << 1));
            check(32'({xtal, rate}), 32'h0000_0008 | 32'(c));
        end
        pulses = 0;
        wr(CKS, 32'hffff_ffff);
        repeat (8) @(posedge clk_sys);
        check(32'(pulses), 32'h0000_0004);
        chk(CKS, 32'h1fff_fdfe);
        check(32'({run, usb, xtal}), 32'({29'h1fff_7de0, 2'h3}));
        $display("clock select done");
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_reset();
        t_bus();
        t_boost();
        t_fixed();
        t_rot();
        t_pll();
        t_clk();
        conclude();
    end
endmodule
`default_nettype wire
